// >>> hdl/ldcl_pkg.sv
/*
  constants of the led driver control latch: shift register and latch
  sizes, field positions inside the 40-bit control latch, reset values.
  assumes nothing of its surroundings.
*/
package ldcl_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int SHIFT_W = 49;
	localparam int CHAN_N = 48;
	localparam int CTRL_W = 40;
	localparam int MC_W = 3;
	localparam int BRIGHT_W = 7;

	// ****************************************
	// shift register fields
	// ****************************************
	localparam int SR_SELECT_BIT = 48;
	localparam int CMD_HI = 47;
	localparam int CMD_LO = 40;
	localparam logic [7:0] WRITE_COMMAND_BYTE = 8'h96;

	// ****************************************
	// control latch fields
	// ****************************************
	localparam int MC_LO = 0;
	localparam int BRIGHT_R_LO = 3;
	localparam int BRIGHT_G_LO = 10;
	localparam int BRIGHT_B_LO = 17;
	localparam int STATUS_SEL_LO = 24;
	localparam int OPEN_THR_LO = 26;
	localparam int SHORT_THR_LO = 29;
	localparam int PS_SEL_LO = 31;

	// ****************************************
	// codes and reset values
	// ****************************************
	localparam logic [1:0] STATUS_NONE = 2'h0;
	localparam logic [1:0] STATUS_OPEN = 2'h1;
	localparam logic [1:0] STATUS_SHORT = 2'h2;
	localparam logic [1:0] PS_DISABLED = 2'h0;
	localparam logic [1:0] PS_WAKE_CLOCK = 2'h1;
	localparam logic [1:0] PS_WAKE_DATA = 2'h2;
	localparam logic [1:0] PS_ALWAYS = 2'h3;
	localparam logic [39:0] CTRL_RESET = 40'h01_8000_0000;
	localparam logic [2:0] MC_RESET = 3'h0;
	localparam logic [48:0] SHIFT_RESET = 49'h0_0000_0000_0000;
	localparam logic [47:0] ONOFF_RESET = 48'h0000_0000_0000;

endpackage

// >>> hdl/ldcl_sync.sv
/*
  two flip-flop synchroniser for a group of asynchronous levels.
  assumes the inputs come from outside the clk_sys domain.
*/
`timescale 1ns/1ps
module ldcl_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// ****************************************
	// two stages
	// ****************************************
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			meta_r <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// >>> hdl/ldcl_latch.sv
/*
  serial control latch of a 48-channel led sink driver: 49-bit shift
  register, 40-bit control latch, 48-bit on/off latch, status load,
  power save state and blanking of the sink outputs.
  assumes shift_clk, serial_in, latch_strobe, blank and the detection
  flags arrive asynchronously; shift_clk is far slower than clk_sys.
*/
//
// Behaviour
// R1 - a 40-bit control latch holds current, brightness and function bits
// R2 - latch rising with shift top bit 1 copies low 40 bits into control
// R3 - control load only when shift bits 47:40 hold write command 96h
// R4 - current code updates only when equal to previous written value
// R5 - current code resets to zero
// R6 - power save select resets to 11, always enabled
// R7 - one 3-bit current code shared by all outputs
// R8 - three 7-bit brightness codes for red, green and blue groups
// R9 - 48 on/off bits, one per output channel
// R10 - function bits hold status select, thresholds and power save select
// R11 - blank low: outputs sink except those with on/off bit 0; the code also holds all outputs off in power save state
// R12 - blank high forces all outputs off
// R13 - host sets grayscale by the blank low duration
// R14 - serial input takes control and on/off data, output gives flags
// R15 - serial input shifts in on each shift clock rising edge
// R16 - serial output comes from shift register top bit
// R17 - status select 01 loads open flags, 10 short flags, else nothing
// R18 - open threshold codes 101 to 111 act as 001
// R19 - short threshold codes 10 and 11 both select high
// R20 - power save modes: off, wake on clock, wake on data, always
`timescale 1ns/1ps
module ldcl_latch
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic shift_clk,
	input wire logic serial_in,
	input wire logic latch_strobe,
	input wire logic blank,
	input wire logic [ldcl_pkg::CHAN_N-1:0] open_led_detect,
	input wire logic [ldcl_pkg::CHAN_N-1:0] shorted_led_detect,
	output logic serial_out,
	output logic [ldcl_pkg::CHAN_N-1:0] sink_output,
	output logic [ldcl_pkg::MC_W-1:0] max_current_code,
	output logic [ldcl_pkg::BRIGHT_W-1:0] colour_brightness_red,
	output logic [ldcl_pkg::BRIGHT_W-1:0] colour_brightness_green,
	output logic [ldcl_pkg::BRIGHT_W-1:0] colour_brightness_blue,
	output logic [1:0] status_load_select,
	output logic [2:0] open_threshold_select,
	output logic [1:0] short_threshold_select,
	output logic [1:0] power_save_select,
	output logic low_power_state
);
	import ldcl_pkg::*;

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [3:0] pins_s;
	logic [2*CHAN_N-1:0] flags_s;
	logic sclk_s;
	logic sin_s;
	logic lat_s;
	logic blank_s;
	logic [CHAN_N-1:0] open_s;
	logic [CHAN_N-1:0] short_s;

	ldcl_sync #(.W(4)) u_sync_pins (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in({shift_clk, serial_in, latch_strobe, blank}),
		.sync_out(pins_s)
	);

	ldcl_sync #(.W(2*CHAN_N)) u_sync_flags (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in({shorted_led_detect, open_led_detect}),
		.sync_out(flags_s)
	);

	assign sclk_s = pins_s[3];
	assign sin_s = pins_s[2];
	assign lat_s = pins_s[1];
	assign blank_s = pins_s[0];
	assign open_s = flags_s[CHAN_N-1:0];
	assign short_s = flags_s[2*CHAN_N-1:CHAN_N];

	// ****************************************
	// edge detection
	// ****************************************
	logic sclk_d_r;
	logic lat_d_r;
	logic sclk_rise;
	logic lat_rise;

	assign sclk_rise = sclk_s & ~sclk_d_r;
	assign lat_rise = lat_s & ~lat_d_r;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			sclk_d_r <= 1'b0;
			lat_d_r <= 1'b0;
		end
		else
		begin
			sclk_d_r <= sclk_s;
			lat_d_r <= lat_s;
		end
	end

	// ****************************************
	// latch state
	// ****************************************
	logic [SHIFT_W-1:0] sr_r;
	logic [SHIFT_W-1:0] sr_nxt;
	logic [CTRL_W-1:0] ctrl_r;
	logic [CTRL_W-1:0] ctrl_nxt;
	logic [MC_W-1:0] mc_prev_r;
	logic [MC_W-1:0] mc_prev_nxt;
	logic [CHAN_N-1:0] onoff_r;
	logic [CHAN_N-1:0] onoff_nxt;
	logic psm_r;
	logic psm_nxt;
	logic [CHAN_N-1:0] sink_r;
	logic [CHAN_N-1:0] sink_nxt;
	logic ctrl_write;
	logic onoff_write;
	logic zero_write;
	logic nonzero_write;

	assign ctrl_write = lat_rise & sr_r[SR_SELECT_BIT]
		& (sr_r[CMD_HI:CMD_LO] == WRITE_COMMAND_BYTE); // R2 R3
	assign onoff_write = lat_rise & ~sr_r[SR_SELECT_BIT];
	assign zero_write = onoff_write & (sr_r[CHAN_N-1:0] == '0);
	assign nonzero_write = onoff_write & (sr_r[CHAN_N-1:0] != '0);

	always_comb
	begin
		sr_nxt = sr_r;
		ctrl_nxt = ctrl_r;
		mc_prev_nxt = mc_prev_r;
		onoff_nxt = onoff_r;
		psm_nxt = psm_r;
		if (sclk_rise)
		begin
			sr_nxt = {sr_r[SHIFT_W-2:0], sin_s}; // R15 R14
		end
		if (ctrl_write)
		begin
			ctrl_nxt = sr_r[CTRL_W-1:0]; // R1 R2
			mc_prev_nxt = sr_r[MC_LO +: MC_W];
			if (sr_r[MC_LO +: MC_W] != mc_prev_r)
			begin
				ctrl_nxt[MC_LO +: MC_W] = ctrl_r[MC_LO +: MC_W]; // R4
			end
		end
		if (onoff_write)
		begin
			onoff_nxt = sr_r[CHAN_N-1:0]; // R9
		end
		if (lat_rise)
		begin
			case (status_load_select)
				STATUS_OPEN: sr_nxt = {1'b0, open_s}; // R17
				STATUS_SHORT: sr_nxt = {1'b0, short_s}; // R17
				default: ;
			endcase
		end
		case (power_save_select) // R20
			PS_DISABLED: psm_nxt = 1'b0;
			PS_WAKE_CLOCK:
			begin
				if (sclk_rise)
					psm_nxt = 1'b0;
				else if (zero_write)
					psm_nxt = 1'b1;
			end
			PS_WAKE_DATA:
			begin
				if (nonzero_write)
					psm_nxt = 1'b0;
				else if (zero_write)
					psm_nxt = 1'b1;
			end
			default:
			begin
				if (sclk_rise || nonzero_write)
					psm_nxt = 1'b0;
				else if (zero_write)
					psm_nxt = 1'b1;
			end
		endcase
		sink_nxt = (blank_s || psm_r) ? '0 : onoff_r; // R11 R12
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			sr_r <= SHIFT_RESET;
			ctrl_r <= CTRL_RESET; // R5 R6
			mc_prev_r <= MC_RESET;
			onoff_r <= ONOFF_RESET;
			psm_r <= 1'b0;
			sink_r <= '0;
		end
		else
		begin
			sr_r <= sr_nxt;
			ctrl_r <= ctrl_nxt;
			mc_prev_r <= mc_prev_nxt;
			onoff_r <= onoff_nxt;
			psm_r <= psm_nxt;
			sink_r <= sink_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign serial_out = sr_r[SHIFT_W-1]; // R16
	assign sink_output = sink_r;
	assign max_current_code = ctrl_r[MC_LO +: MC_W]; // R7
	assign colour_brightness_red = ctrl_r[BRIGHT_R_LO +: BRIGHT_W]; // R8
	assign colour_brightness_green = ctrl_r[BRIGHT_G_LO +: BRIGHT_W]; // R8
	assign colour_brightness_blue = ctrl_r[BRIGHT_B_LO +: BRIGHT_W]; // R8
	assign status_load_select = ctrl_r[STATUS_SEL_LO +: 2]; // R10
	assign open_threshold_select = (ctrl_r[OPEN_THR_LO + 2] && ctrl_r[OPEN_THR_LO +: 2] != 2'h0)
		? 3'h1 : ctrl_r[OPEN_THR_LO +: 3]; // R18
	assign short_threshold_select = ctrl_r[SHORT_THR_LO + 1]
		? 2'h2 : ctrl_r[SHORT_THR_LO +: 2]; // R19
	assign power_save_select = ctrl_r[PS_SEL_LO +: 2];
	assign low_power_state = psm_r;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	a_blank_forces_off: assert property ( // R12
		blank_s |=> sink_output == '0)
		else $error("outputs not off while blank high");

	a_sink_follows_onoff: assert property ( // R11
		!blank_s && !psm_r |=> sink_output == $past(onoff_r))
		else $error("outputs do not follow on/off latch");

	a_shift_in_bit: assert property ( // R15
		sclk_rise && !lat_rise |=> sr_r == {$past(sr_r[SHIFT_W-2:0]), $past(sin_s)})
		else $error("serial bit not shifted in");

	a_serial_out_top: assert property ( // R16
		sclk_rise && !lat_rise |=> serial_out == $past(sr_r[SHIFT_W-2]))
		else $error("serial output not from top bit");

	a_cmd_guard: assert property ( // R3
		lat_rise && sr_r[CMD_HI:CMD_LO] != WRITE_COMMAND_BYTE |=> $stable(ctrl_r))
		else $error("control latch loaded without command byte");

	a_ctrl_load: assert property ( // R2
		ctrl_write |=> ctrl_r[CTRL_W-1:MC_W] == $past(sr_r[CTRL_W-1:MC_W]))
		else $error("control latch not loaded");

	a_mc_single: assert property ( // R4
		ctrl_write && sr_r[MC_LO +: MC_W] != mc_prev_r |=> $stable(max_current_code))
		else $error("current code changed on first write");

	a_mc_twice: assert property ( // R4
		ctrl_write && sr_r[MC_LO +: MC_W] == mc_prev_r
		|=> max_current_code == $past(sr_r[MC_LO +: MC_W]))
		else $error("current code not updated on matching write");

	a_status_open: assert property ( // R17
		lat_rise && status_load_select == STATUS_OPEN |=> sr_r == {1'b0, $past(open_s)})
		else $error("open flags not loaded");

	a_psm_disabled: assert property ( // R20
		power_save_select == PS_DISABLED |=> !low_power_state)
		else $error("power save entered while disabled");

	a_psm_enter: assert property ( // R20
		zero_write && !sclk_rise && power_save_select != PS_DISABLED
		|=> low_power_state ##1 sink_output == '0)
		else $error("power save not entered on all-zero write");

	a_status_short: assert property ( // R17
		lat_rise && status_load_select == STATUS_SHORT |=> sr_r == {1'b0, $past(short_s)})
		else $error("short flags not loaded");

	a_onoff_load: assert property ( // R9
		onoff_write |=> onoff_r == $past(sr_r[CHAN_N-1:0]))
		else $error("on/off latch not loaded");

	a_psm_wake_clock: assert property ( // R20
		power_save_select == PS_WAKE_CLOCK && sclk_rise |=> !low_power_state)
		else $error("power save not left on shift clock edge");

	a_psm_wake_data: assert property ( // R20
		power_save_select != PS_WAKE_CLOCK && nonzero_write |=> !low_power_state)
		else $error("power save not left on nonzero write");

endmodule

// >>> tb/ldcl_host.sv
/*
  host model: shifts 49-bit frames msb first on an 800 ns shift clock,
  pulses the latch strobe and captures serial_out before each shift.
  assumes the bench clk_sys of 100 ns.
*/
`timescale 1ns/1ps
module ldcl_host (
	input wire logic clk_sys,
	input wire logic serial_out,
	output logic shift_clk,
	output logic serial_in,
	output logic latch_strobe
);
	// ****************************************
	// frame transfer
	// ****************************************
	initial
	begin
		shift_clk = 1'b0;
		serial_in = 1'b0;
		latch_strobe = 1'b0;
	end

	task automatic send(input logic [48:0] frame, output logic [48:0] seen);
		for (int i = 48; i >= 0; i--)
		begin
			@(posedge clk_sys);
			shift_clk <= 1'b0;
			serial_in <= frame[i];
			repeat (4) @(posedge clk_sys);
			seen[i] = serial_out;
			shift_clk <= 1'b1;
			repeat (3) @(posedge clk_sys);
		end
		@(posedge clk_sys);
		shift_clk <= 1'b0;
		repeat (4) @(posedge clk_sys);
		serial_in <= ~frame[0];
		latch_strobe <= 1'b1;
		repeat (8) @(posedge clk_sys);
		latch_strobe <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule

// >>> tb/ldcl_latch_test.sv
/*
  testbench of the control latch: frames through the host model,
  checks of the decoded fields, outputs and readback.
  assumes the ldcl_pkg sizes.
*/
`timescale 1ns/1ps
module ldcl_latch_test;
	import ldcl_pkg::*;
	logic clk_sys, reset, blank, shift_clk, serial_in, latch_strobe, serial_out;
	logic low_power_state;
	logic [CHAN_N-1:0] open_led_detect, shorted_led_detect, sink_output;
	logic [2:0] max_current_code, open_threshold_select;
	logic [6:0] colour_brightness_red, colour_brightness_green, colour_brightness_blue;
	logic [1:0] status_load_select, short_threshold_select, power_save_select;
	logic [48:0] seen, f, exp, fields;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;

	assign fields = {16'h0, power_save_select, short_threshold_select, open_threshold_select,
		status_load_select, colour_brightness_blue, colour_brightness_green,
		colour_brightness_red, max_current_code};

	ldcl_latch i_dut (.clk_sys, .reset, .shift_clk, .serial_in, .latch_strobe, .blank,
		.open_led_detect, .shorted_led_detect, .serial_out, .sink_output, .max_current_code,
		.colour_brightness_red, .colour_brightness_green, .colour_brightness_blue,
		.status_load_select, .open_threshold_select, .short_threshold_select,
		.power_save_select, .low_power_state);
	ldcl_host i_host (.clk_sys, .serial_out, .shift_clk, .serial_in, .latch_strobe);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [48:0] ctrl(input logic [7:0] cmd, input logic [2:0] mc,
		input logic [1:0] st, input logic [2:0] op, input logic [1:0] sh, input logic [1:0] ps);
		return {1'b1, cmd, 7'h00, ps, sh, op, st, 7'h33, 7'h22, 7'h11, mc};
	endfunction

	task automatic check(input logic [48:0] got, input logic [48:0] want);
		checks++;
		if (got !== want)
		begin
			miscompares++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, got, want);
		end
	endtask

	task automatic wr(input logic [48:0] frame);
		i_host.send(frame, seen);
	endtask

	task automatic report_and_stop();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ****************************************
	// clock and timeout
	// ****************************************
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			miscompares++;
			report_and_stop();
		end
	end

	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		reset = 1'b1;
		blank = 1'b0;
		open_led_detect = 48'h1234_5678_9abc;
		shorted_led_detect = 48'hfedc_ba98_7654;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		check(fields, {16'h0, 2'h3, 31'h0});
		check({serial_out, sink_output}, 49'h0);
		$display("test reset done");
		f = ctrl(8'h96, 3'h5, 2'h0, 3'h4, 2'h1, 2'h0);
		wr(f);
		check(fields, {16'h0, f[32:3], 3'h0});
		wr(f);
		check(fields, {16'h0, f[32:0]});
		wr(ctrl(8'h96, 3'h6, 2'h0, 3'h4, 2'h1, 2'h0));
		check(fields, {16'h0, f[32:0]});
		wr(ctrl(8'h95, 3'h5, 2'h3, 3'h2, 2'h0, 2'h3));
		check(fields, {16'h0, f[32:0]});
		$display("test control write done");
		wr({1'b0, 48'ha5a5_0000_ffff});
		check({1'b0, sink_output}, 49'h0_a5a5_0000_ffff);
		check(fields, {16'h0, f[32:0]});
		blank <= 1'b1;
		repeat (8) @(posedge clk_sys);
		check({1'b0, sink_output}, 49'h0);
		blank <= 1'b0;
		$display("test blanking done");
		for (int c = 0; c < 8; c++)
		begin
			f = ctrl(8'h96, 3'h5, 2'h0, c[2:0], c[1:0], 2'h0);
			wr(f);
			exp = {16'h0, f[32:0]};
			if (c > 4)
				exp[28:26] = 3'h1;
			if (c[1:0] == 2'h3)
				exp[30:29] = 2'h2;
			check(fields, exp);
		end
		$display("test thresholds done");
		for (int c = 0; c < 4; c++)
		begin
			wr(ctrl(8'h96, 3'h5, c[1:0], 3'h0, 2'h0, 2'h0));
			wr({1'b0, 48'h0f0f_3c3c_0ff0});
			wr({1'b0, 48'h0f0f_3c3c_0ff0});
			exp = {1'b0, 48'h0f0f_3c3c_0ff0};
			if (c == 1)
				exp = {1'b0, open_led_detect};
			if (c == 2)
				exp = {1'b0, shorted_led_detect};
			check(seen, exp);
		end
		$display("test status load done");
		for (int c = 0; c < 4; c++)
		begin
			wr(ctrl(8'h96, 3'h5, 2'h0, 3'h0, 2'h0, c[1:0]));
			wr(49'h0);
			check({48'h0, low_power_state}, {48'h0, c != 0});
			wr({1'b0, 48'h0000_0000_0001});
			check({48'h0, low_power_state}, 49'h0);
			check({1'b0, sink_output}, 49'h1);
		end
		$display("test power save done");
		report_and_stop();
	end
endmodule
